/* tb_video_sync_timer_link.sv */
// self-checking bench for the video sync timer link block
`timescale 1ns/1ps
`default_nettype none
module tb_video_sync_timer_link;
  import video_sync_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, hs, vs, run = 1'b0;
  logic        h_out, v_out, g_h, g_v, l_out, clamp;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [31:0] r, r2;
  logic        e;
  int          k;
  video_src src (.pclk(pclk), .run(run), .hs(hs), .vs(vs));
  video_sync_timer_link dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .horiz_sync_in(hs),
    .vert_sync_in(vs), .horiz_out_select_path(h_out), .vert_out_select_path(v_out),
    .gen_horiz_sync(g_h), .gen_vert_sync(g_v), .line_timer_out(l_out),
    .clamp_pulse_four(clamp));
  always #50 pclk = ~pclk;
  // hang guard: the whole sequence needs under two thousand clocks
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset values, read back of control bits, unmapped access
  task automatic t_regs();
    apb(1'b0, OFF_COMPARE_A, 0);
    chk("compare_a_rst", r, {16'h0000, COMPARE_A_RST});
    apb(1'b1, OFF_MODE_CTRL, 32'h0000_00C0);
    apb(1'b0, OFF_MODE_CTRL, 0);
    chk("mode_ctrl", r, 32'h0000_00C0);
    apb(1'b1, OFF_MASK_OFFSET, 32'hFFFF_FF5A);
    apb(1'b0, OFF_MASK_OFFSET, 0);
    chk("mask_offset", r, 32'h0000_005A);
    apb(1'b1, 12'h030, 32'h0000_1234);
    chk("unmapped_err", {31'd0, e}, 32'h1);
    chk("unmapped_data", r, 32'h0);
  endtask
  // free counter at clock/8, capture on rising line edge, unmasked follow
  task automatic t_follow();
    apb(1'b1, OFF_MODE_CTRL, 32'h0);
    apb(1'b1, OFF_FREE_CTRL, 32'h0000_0011);
    apb(1'b0, OFF_FREE_COUNTER, 0);
    r2 = r;
    repeat (77) @(posedge pclk);
    apb(1'b0, OFF_FREE_COUNTER, 0);
    chk("free_rate", r - r2, 32'd10);
    run <= 1'b1;
    @(posedge pclk);
    while (hs !== 1'b1) @(posedge pclk);
    repeat (5) @(posedge pclk);
    chk("h_follow_rise", {31'd0, h_out}, 32'h1);
    apb(1'b0, OFF_EDGE_CAPTURE, 0);
    r2 = r;
    apb(1'b0, OFF_FREE_COUNTER, 0);
    chk("capture_near", {31'd0, (r - r2) <= 32'd2}, 32'h1);
    while (hs !== 1'b0) @(posedge pclk);
    chk("h_pre_fall", {31'd0, h_out}, 32'h1);
    repeat (5) @(posedge pclk);
    chk("h_follow_fall", {31'd0, h_out}, 32'h0);
    run <= 1'b0;
  endtask
  // generated line: const a 3 at clock/4 gives 16 clocks, clamp 6 clocks
  task automatic t_gen();
    apb(1'b1, OFF_HORIZ_TMR, 32'h0609_0103);
    while (g_h !== 1'b1) @(posedge pclk);
    while (g_h !== 1'b0) @(posedge pclk);
    k = 0;
    while (clamp !== 1'b1 && k < 3) begin
      @(posedge pclk);
      k = k + 1;
    end
    chk("clamp_rise", {31'd0, k <= 2}, 32'h1);
    k = 0;
    while (clamp === 1'b1) begin
      @(posedge pclk);
      k = k + 1;
    end
    chk("clamp_len", k, 32'd6);
    while (g_h !== 1'b1) @(posedge pclk);
    k = 0;
    @(posedge pclk);
    while (g_h !== 1'b0) begin
      @(posedge pclk);
      k = k + 1;
    end
    while (g_h !== 1'b1) begin
      @(posedge pclk);
      k = k + 1;
    end
    chk("gen_period", k + 1, 32'd16);
  endtask
  // generated frame: 16 low and 8 high free ticks, 192 clocks, twelve lines
  task automatic t_vert();
    apb(1'b1, OFF_LOW_ADDEND, 32'h0000_0010);
    apb(1'b1, OFF_HIGH_ADDEND, 32'h0000_0008);
    apb(1'b0, OFF_FREE_COUNTER, 0);
    apb(1'b1, OFF_COMPARE_A, r + 32'h0000_0020);
    apb(1'b1, OFF_MODE_CTRL, 32'h0000_0040);
    while (g_v !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    chk("gv_horiz_restart", {31'd0, g_h}, 32'h1);
    k = 1;
    while (g_v === 1'b1) begin
      @(posedge pclk);
      k = k + 1;
    end
    chk("gv_high_len", k, 32'd64);
  endtask
  // window 3 to 6 free ticks after the captured rise swallows the line fall
  task automatic t_mask();
    apb(1'b1, OFF_MASK_OFFSET, 32'h0000_0003);
    apb(1'b1, OFF_MODE_CTRL, 32'h0000_0080);
    apb(1'b1, OFF_SYNC_CTRL, 32'h0000_0001);
    apb(1'b1, OFF_LINE_TMR, 32'h030D_0000);
    run <= 1'b1;
    @(posedge pclk);
    while (hs !== 1'b0) @(posedge pclk);
    repeat (8) @(posedge pclk);
    chk("h_masked_fall", {31'd0, h_out}, 32'h1);
    chk("line_toggle", {31'd0, l_out}, 32'h1);
    run <= 1'b0;
  endtask
  // fall modification: vertical path drops on the third line rise after its fall
  task automatic t_vpath();
    apb(1'b1, OFF_SYNC_CTRL, 32'h0000_0002);
    apb(1'b1, OFF_LINE_TMR, 32'h001D_02FF);
    run <= 1'b1;
    repeat (700) @(posedge pclk);
    chk("v_fall_held", {31'd0, v_out}, 32'h1);
    repeat (110) @(posedge pclk);
    chk("v_fall_mod", {31'd0, v_out}, 32'h0);
    run <= 1'b0;
  endtask
  task automatic test_done();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_follow();
    t_gen();
    t_vert();
    t_mask();
    t_vpath();
    test_done();
  end
endmodule
`default_nettype wire

/* video_src.sv */
// behavioural video sync source driving the incoming sync pins
`timescale 1ns/1ps
`default_nettype none
module video_src (
  input  wire logic pclk,
  input  wire logic run,
  output logic      hs,
  output logic      vs
);
  logic [7:0] n_q = 8'h00;
  logic [2:0] ln_q = 3'h0;
  // line of 200 clocks, frame of 8 lines; both stop low when not running
  always @(posedge pclk) begin
    n_q <= (run && n_q != 8'd199) ? n_q + 8'd1 : 8'h00;
    if (!run) begin
      ln_q <= 3'h0;
    end else if (n_q == 8'd199) begin
      ln_q <= ln_q + 3'h1;
    end
  end
  // 20% duty so that double-rate masking stays usable
  assign hs = run && (n_q < 8'd40);
  // vertical high for the first line of each frame
  assign vs = run && (ln_q == 3'h0);
endmodule
`default_nettype wire

/* video_sync_pkg.sv */
// shared constants for the video sync timer link block
`default_nettype none
package video_sync_pkg;
  localparam int unsigned ADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] OFF_MASK_OFFSET  = 12'h000;
  localparam logic [11:0] OFF_MODE_CTRL    = 12'h004;
  localparam logic [11:0] OFF_LOW_ADDEND   = 12'h008;
  localparam logic [11:0] OFF_HIGH_ADDEND  = 12'h00C;
  localparam logic [11:0] OFF_FREE_CTRL    = 12'h010;
  localparam logic [11:0] OFF_SYNC_CTRL    = 12'h014;
  localparam logic [11:0] OFF_LINE_TMR     = 12'h018;
  localparam logic [11:0] OFF_HORIZ_TMR    = 12'h01C;
  localparam logic [11:0] OFF_COMPARE_A    = 12'h020;
  localparam logic [11:0] OFF_EDGE_CAPTURE = 12'h024;
  localparam logic [11:0] OFF_FREE_COUNTER = 12'h028;
  localparam logic [11:0] OFF_STATUS       = 12'h02C;
  // compare_mode_control fields
  localparam int unsigned MASK_MODE_BIT = 7;
  localparam int unsigned ALT_ADD_BIT   = 6;
  // free timer control fields
  localparam int unsigned FREE_CKS_LSB  = 0;
  localparam int unsigned FREE_CLR_BIT  = 2;
  localparam int unsigned CAP_EDGE_BIT  = 4;
  // sync control fields
  localparam int unsigned DLR_BIT       = 0;
  localparam int unsigned FALL_MOD_BIT  = 1;
  localparam int unsigned ALIGN_BIT     = 2;
  // 8-bit timer configuration word layout
  localparam int unsigned TMR_CA_LSB    = 0;
  localparam int unsigned TMR_CB_LSB    = 8;
  localparam int unsigned TMR_CKS_LSB   = 16;
  localparam int unsigned TMR_COUNTER_CLEAR_SELECT_LSB  = 19;
  localparam int unsigned TMR_OS_LSB    = 24;
  localparam int unsigned TMR_CFG_W     = 28;
  // clock select codes
  localparam logic [1:0] FREE_CKS_DIV2  = 2'h0;
  localparam logic [1:0] FREE_CKS_DIV8  = 2'h1;
  localparam logic [1:0] FREE_CKS_DIV32 = 2'h2;
  localparam logic [2:0] TMR_CKS_DIV4   = 3'h1;
  localparam logic [2:0] TMR_CKS_HRISE  = 3'h5;
  // counter clear select codes
  localparam logic [1:0] COUNTER_CLEAR_SELECT_MATCH_A   = 2'h1;
  localparam logic [1:0] COUNTER_CLEAR_SELECT_MATCH_B   = 2'h2;
  localparam logic [1:0] COUNTER_CLEAR_SELECT_RESET_IN  = 2'h3;
  // output select actions, per 2-bit half
  localparam logic [1:0] OS_LOW         = 2'h1;
  localparam logic [1:0] OS_HIGH        = 2'h2;
  localparam logic [1:0] OS_TOGGLE      = 2'h3;
  // reset values
  localparam logic [15:0] COMPARE_A_RST = 16'hFFFF;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  // clamp pulse length in system clocks
  localparam logic [2:0]  CLAMP_CYCLES  = 3'h6;
endpackage
`default_nettype wire

/* video_sync_timer_link.sv */
// video sync masking, vertical fall modification and internal sync generation
// Summary of operation
// - mask window runs between capture plus offset and capture plus twice offset.
// - capture edge select 1 copies free counter on horizontal rising edges.
// - unmasked horizontal path follows incoming rises and falls.
// - in mask windows horizontal edges and captures are ignored.
// - mask mode enable bit 7 puts capture into offset mask mode when sync control bit 0 is also set.
// - free clock select 01 ticks at clock over 8; clear select 0 never clears.
// - line timer counts horizontal rises, clears on vertical fall.
// - fall modification clears vertical path on line timer match B.
// - optional alignment of vertical fall to next horizontal rise.
// - select 0011 toggles on A; 1001 sets on B, clears on A.
// - each compare A match adds low then high addend alternately.
// - generated vertical rises on the high addition, falls on the low addition.
// - alternate add enable bit 6 turns on the alternating addition.
// - generated horizontal goes high on match A, low on match B.
// - clear select 01 clears on match A; clock select 001 is quarter rate.
// - generated vertical rise acts as horizontal timer match A.
// - clamp rises one clock after horizontal fall, high six clocks.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module video_sync_timer_link #(
  parameter int unsigned FREE_W = 16
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [video_sync_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              horiz_sync_in,
  input  wire logic                              vert_sync_in,
  output logic                                   horiz_out_select_path,
  output logic                                   vert_out_select_path,
  output logic                                   gen_horiz_sync,
  output logic                                   gen_vert_sync,
  output logic                                   line_timer_out,
  output logic                                   clamp_pulse_four
);
  import video_sync_pkg::*;

  // the register map and the adders assume a 16-bit free counter
  if (FREE_W != 16) begin : g_width_check
    $error("FREE_W must be 16");
  end

  // picks the counting pulse of an 8-bit timer
  function automatic logic tmr_tick(input logic [2:0] clock_select, input logic [4:0] pre,
                                    input logic hrise);
    tmr_tick = ((clock_select == TMR_CKS_DIV4) && (pre[1:0] == 2'h3)) ||
               ((clock_select == TMR_CKS_HRISE) && hrise);
  endfunction

  // applies one 2-bit output select action
  function automatic logic os_act(input logic [1:0] act, input logic cur);
    case (act)
      OS_LOW:    os_act = 1'b0;
      OS_HIGH:   os_act = 1'b1;
      OS_TOGGLE: os_act = ~cur;
      default:   os_act = cur;
    endcase
  endfunction

  // -------- registers --------
  logic [7:0]           mask_offset_q;
  logic [7:0]           compare_mode_control_q;
  logic [15:0]          low_interval_addend_q;
  logic [15:0]          high_interval_addend_q;
  logic [7:0]           free_ctrl_q;
  logic [2:0]           sync_ctrl_q;
  logic [TMR_CFG_W-1:0] tmr_cfg_q [2];
  logic [15:0]          compare_a_reg_q;
  logic [15:0]          edge_capture_reg_q;
  logic [15:0]          free_counter_q;
  logic [4:0]           presc_q;
  logic                 phase_q;
  logic                 mask_q;
  logic                 pend_q;
  logic [2:0]           clamp_cnt_q;
  logic                 gvert_prev_q;
  logic                 ghoriz_prev_q;
  logic [1:0]           in_meta_q;
  logic [1:0]           in_sync_q;
  logic [1:0]           in_prev_q;
  logic [7:0]           byte_counter_q [2];
  logic [1:0]           tmr_out_q;
  logic                 wr_en;
  logic                 acc;
  logic [31:0]          rd_d;
  logic                 hit_d;

  // -------- input synchronisers, bit 0 horizontal, bit 1 vertical --------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta_q <= 2'h0;
      in_sync_q <= 2'h0;
      in_prev_q <= 2'h0;
    end else begin
      in_meta_q <= {vert_sync_in, horiz_sync_in};
      in_sync_q <= in_meta_q;
      in_prev_q <= in_sync_q;
    end
  end

  logic hrise, hfall, vrise, vfall;
  assign hrise = in_sync_q[0] & ~in_prev_q[0];
  assign hfall = ~in_sync_q[0] & in_prev_q[0];
  assign vrise = in_sync_q[1] & ~in_prev_q[1];
  assign vfall = ~in_sync_q[1] & in_prev_q[1];

  // -------- APB slave, no wait states: pready comes from a flop --------
  assign acc   = psel & penable & pready;
  assign wr_en = acc & pwrite & ~pslverr;

  // address decode and read mux
  always_comb begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    if (paddr == OFF_MASK_OFFSET) begin
      rd_d[7:0] = mask_offset_q;
    end else if (paddr == OFF_MODE_CTRL) begin
      rd_d[7:0] = compare_mode_control_q;
    end else if (paddr == OFF_LOW_ADDEND) begin
      rd_d[15:0] = low_interval_addend_q;
    end else if (paddr == OFF_HIGH_ADDEND) begin
      rd_d[15:0] = high_interval_addend_q;
    end else if (paddr == OFF_FREE_CTRL) begin
      rd_d[7:0] = free_ctrl_q;
    end else if (paddr == OFF_SYNC_CTRL) begin
      rd_d[2:0] = sync_ctrl_q;
    end else if (paddr == OFF_LINE_TMR) begin
      rd_d[TMR_CFG_W-1:0] = tmr_cfg_q[0];
    end else if (paddr == OFF_HORIZ_TMR) begin
      rd_d[TMR_CFG_W-1:0] = tmr_cfg_q[1];
    end else if (paddr == OFF_COMPARE_A) begin
      rd_d[15:0] = compare_a_reg_q;
    end else if (paddr == OFF_EDGE_CAPTURE) begin
      rd_d[15:0] = edge_capture_reg_q;
    end else if (paddr == OFF_FREE_COUNTER) begin
      rd_d[15:0] = free_counter_q;
    end else if (paddr == OFF_STATUS) begin
      rd_d = {byte_counter_q[1], byte_counter_q[0], 8'h00, clamp_pulse_four, line_timer_out, gen_vert_sync,
              gen_horiz_sync, vert_out_select_path, horiz_out_select_path, mask_q, phase_q};
    end else begin
      hit_d = 1'b0;
    end
  end

  // answer registered in the setup cycle, dropped after the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_d;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_offset_q          <= BYTE_RST;
      compare_mode_control_q <= BYTE_RST;
      low_interval_addend_q  <= WORD_RST;
      high_interval_addend_q <= WORD_RST;
      free_ctrl_q            <= BYTE_RST;
      sync_ctrl_q            <= 3'h0;
      tmr_cfg_q[0]           <= '0;
      tmr_cfg_q[1]           <= '0;
    end else if (wr_en) begin
      if (paddr == OFF_MASK_OFFSET) begin
        mask_offset_q <= pwdata[7:0];
      end else if (paddr == OFF_MODE_CTRL) begin
        compare_mode_control_q <= pwdata[7:0];
      end else if (paddr == OFF_LOW_ADDEND) begin
        low_interval_addend_q <= pwdata[15:0];
      end else if (paddr == OFF_HIGH_ADDEND) begin
        high_interval_addend_q <= pwdata[15:0];
      end else if (paddr == OFF_FREE_CTRL) begin
        free_ctrl_q <= pwdata[7:0];
      end else if (paddr == OFF_SYNC_CTRL) begin
        sync_ctrl_q <= pwdata[2:0];
      end else if (paddr == OFF_LINE_TMR) begin
        tmr_cfg_q[0] <= pwdata[TMR_CFG_W-1:0];
      end else if (paddr == OFF_HORIZ_TMR) begin
        tmr_cfg_q[1] <= pwdata[TMR_CFG_W-1:0];
      end
    end
  end

  // -------- free running counter --------
  logic [1:0] free_cks;
  logic       free_tick;
  logic       cmp_a_match;
  assign free_cks    = free_ctrl_q[FREE_CKS_LSB +: 2];
  assign free_tick   = (free_cks == FREE_CKS_DIV2)  ? presc_q[0] :
                       (free_cks == FREE_CKS_DIV8)  ? (presc_q[2:0] == 3'h7) :
                       (free_cks == FREE_CKS_DIV32) ? (presc_q == 5'h1F) : 1'b0;
  assign cmp_a_match = free_tick & (free_counter_q == compare_a_reg_q);

  // prescaler and counter; clear on match only when clear select is 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q        <= 5'h00;
      free_counter_q <= WORD_RST;
    end else begin
      presc_q <= presc_q + 5'h01;
      if (cmp_a_match && free_ctrl_q[FREE_CLR_BIT]) begin
        free_counter_q <= WORD_RST;
      end else if (free_tick) begin
        free_counter_q <= free_counter_q + 16'h0001;
      end
    end
  end

  // -------- double line rate masking --------
  logic        mask_on;
  logic        edge_ok;
  logic        cap_edge;
  logic [15:0] mask_start;
  logic [15:0] mask_end;
  assign mask_on    = compare_mode_control_q[MASK_MODE_BIT] & sync_ctrl_q[DLR_BIT];
  assign edge_ok    = ~(mask_on & mask_q);
  assign cap_edge   = free_ctrl_q[CAP_EDGE_BIT] ? hrise : hfall;
  assign mask_start = edge_capture_reg_q + {8'h00, mask_offset_q};
  assign mask_end   = edge_capture_reg_q + {7'h00, mask_offset_q, 1'b0};

  // capture and horizontal path share the edge qualifier that the mask window drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_capture_reg_q    <= WORD_RST;
      mask_q                <= 1'b0;
      horiz_out_select_path <= 1'b0;
    end else begin
      if (cap_edge && edge_ok) begin
        edge_capture_reg_q <= free_counter_q;
      end
      if (!mask_on) begin
        mask_q <= 1'b0;
      end else if (free_tick && free_counter_q == mask_end) begin
        mask_q <= 1'b0;
      end else if (free_tick && free_counter_q == mask_start) begin
        mask_q <= 1'b1;
      end
      // edges falling inside the window are dropped, not delayed
      if (hrise && edge_ok) begin
        horiz_out_select_path <= 1'b1;
      end else if (hfall && edge_ok) begin
        horiz_out_select_path <= 1'b0;
      end
    end
  end

  // -------- alternating compare A additions, generated vertical --------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_reg_q <= COMPARE_A_RST;
      phase_q         <= 1'b0;
      gen_vert_sync   <= 1'b0;
    end else begin
      if (wr_en && paddr == OFF_COMPARE_A) begin
        compare_a_reg_q <= pwdata[15:0];
        phase_q         <= 1'b0;
      end else if (cmp_a_match && compare_mode_control_q[ALT_ADD_BIT]) begin
        compare_a_reg_q <= compare_a_reg_q +
                           (phase_q ? high_interval_addend_q : low_interval_addend_q);
        phase_q         <= ~phase_q;
        gen_vert_sync   <= phase_q;
      end
    end
  end

  // -------- two 8-bit timers: 0 counts lines, 1 makes horizontal sync --------
  logic [1:0] t_ma;
  logic [1:0] t_mb;
  logic [1:0] t_rst;
  assign t_rst[0] = vfall;
  assign t_rst[1] = gen_vert_sync & ~gvert_prev_q;

  for (genvar t = 0; t < 2; t++) begin : g_tmr
    logic [7:0] ca;
    logic [7:0] cb;
    logic [1:0] counter_clear_select;
    logic [3:0] os;
    logic       tick;
    logic       clr;
    assign ca   = tmr_cfg_q[t][TMR_CA_LSB +: 8];
    assign cb   = tmr_cfg_q[t][TMR_CB_LSB +: 8];
    assign counter_clear_select = tmr_cfg_q[t][TMR_COUNTER_CLEAR_SELECT_LSB +: 2];
    assign os   = tmr_cfg_q[t][TMR_OS_LSB +: 4];
    assign tick = tmr_tick(tmr_cfg_q[t][TMR_CKS_LSB +: 3], presc_q, hrise);
    // only the horizontal timer treats its reset input as a match A
    assign t_ma[t] = (tick && byte_counter_q[t] == ca) || (t == 1 && t_rst[t]);
    assign t_mb[t] = tick && byte_counter_q[t] == cb;
    assign clr     = (counter_clear_select == COUNTER_CLEAR_SELECT_MATCH_A  && t_ma[t]) ||
                     (counter_clear_select == COUNTER_CLEAR_SELECT_MATCH_B  && t_mb[t]) ||
                     (counter_clear_select == COUNTER_CLEAR_SELECT_RESET_IN && t_rst[t]) ||
                     (t == 1 && t_rst[t]);

    // match A wins over match B so equal constants leave A's level
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        byte_counter_q[t]    <= 8'h00;
        tmr_out_q[t] <= 1'b0;
      end else begin
        if (clr) begin
          byte_counter_q[t] <= 8'h00;
        end else if (tick) begin
          byte_counter_q[t] <= byte_counter_q[t] + 8'h01;
        end
        if (t_ma[t]) begin
          tmr_out_q[t] <= os_act(os[1:0], tmr_out_q[t]);
        end else if (t_mb[t]) begin
          tmr_out_q[t] <= os_act(os[3:2], tmr_out_q[t]);
        end
      end
    end
  end

  assign line_timer_out = tmr_out_q[0];
  assign gen_horiz_sync = tmr_out_q[1];

  // -------- vertical path with fall modification and alignment --------
  logic clr_req;
  assign clr_req = sync_ctrl_q[FALL_MOD_BIT] ? t_mb[0] : vfall;

  // a held fall waits for the next horizontal rise; a new rise cancels it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vert_out_select_path <= 1'b0;
      pend_q               <= 1'b0;
    end else if (vrise) begin
      vert_out_select_path <= 1'b1;
      pend_q               <= 1'b0;
    end else if (sync_ctrl_q[ALIGN_BIT]) begin
      if (pend_q && hrise) begin
        vert_out_select_path <= 1'b0;
        pend_q               <= 1'b0;
      end else if (clr_req) begin
        pend_q <= 1'b1;
      end
    end else begin
      pend_q <= 1'b0;
      if (clr_req) begin
        vert_out_select_path <= 1'b0;
      end
    end
  end

  // -------- clamp pulse after each generated horizontal fall --------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gvert_prev_q     <= 1'b0;
      ghoriz_prev_q    <= 1'b0;
      clamp_cnt_q      <= 3'h0;
      clamp_pulse_four <= 1'b0;
    end else begin
      gvert_prev_q  <= gen_vert_sync;
      ghoriz_prev_q <= gen_horiz_sync;
      if (ghoriz_prev_q && !gen_horiz_sync) begin
        clamp_pulse_four <= 1'b1;
        clamp_cnt_q      <= CLAMP_CYCLES - 3'h1;
      end else if (clamp_cnt_q != 3'h0) begin
        clamp_cnt_q <= clamp_cnt_q - 3'h1;
      end else begin
        clamp_pulse_four <= 1'b0;
      end
    end
  end

  // -------- assertions --------
  default clocking cb_a @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence clamp_high6;
    clamp_pulse_four [*6] ##1 !clamp_pulse_four;
  endsequence

  capture_load_a: assert property (
    (free_ctrl_q[CAP_EDGE_BIT] && hrise && edge_ok) |=>
      edge_capture_reg_q == $past(free_counter_q))
    else $error("capture did not take the free counter");

  mask_block_a: assert property (
    (mask_on && mask_q && (hrise || hfall)) |=> $stable(horiz_out_select_path))
    else $error("horizontal edge passed inside mask window");

  horiz_follow_a: assert property (
    (!mask_on && hrise) |=> horiz_out_select_path ##0 $past(in_sync_q[0]))
    else $error("horizontal path missed a rise");

  free_div_a: assert property (
    (free_cks == FREE_CKS_DIV8 && !free_ctrl_q[FREE_CLR_BIT] && presc_q[2:0] != 3'h7)
      |=> $stable(free_counter_q))
    else $error("free counter moved off its divide by 8 tick");

  alt_add_a: assert property (
    (cmp_a_match && compare_mode_control_q[ALT_ADD_BIT] && !phase_q && !wr_en) |=>
      compare_a_reg_q == $past(compare_a_reg_q) + $past(low_interval_addend_q) ##0 phase_q)
    else $error("low addend not added to compare A");

  gen_vert_a: assert property (
    (cmp_a_match && compare_mode_control_q[ALT_ADD_BIT] && !wr_en) |=>
      gen_vert_sync == !phase_q)
    else $error("generated vertical level wrong after match");

  fall_mod_a: assert property (
    (sync_ctrl_q[FALL_MOD_BIT] && !sync_ctrl_q[ALIGN_BIT] && t_mb[0] && !vrise) |=>
      !vert_out_select_path)
    else $error("fall modification did not clear vertical path");

  align_hold_a: assert property (
    (sync_ctrl_q[ALIGN_BIT] && vert_out_select_path && !hrise && !vrise) |=>
      vert_out_select_path)
    else $error("aligned vertical fell without a horizontal rise");

  horiz_reset_a: assert property (
    (t_rst[1] && tmr_cfg_q[1][TMR_OS_LSB +: 4] == 4'h6) |=>
      gen_horiz_sync && byte_counter_q[1] == 8'h00)
    else $error("generated vertical rise did not restart horizontal timer");

  line_toggle_a: assert property (
    (t_ma[0] && tmr_cfg_q[0][TMR_OS_LSB +: 4] == 4'h3) |=>
      line_timer_out != $past(line_timer_out))
    else $error("line timer output did not toggle on match A");

  clamp_len_a: assert property (
    (ghoriz_prev_q && !gen_horiz_sync) |=> clamp_high6)
    else $error("clamp pulse not six clocks long");

endmodule
`default_nettype wire
